// ===== pkg/optimizer_defs.vh
`ifndef OPTIMIZER_DEFS_VH
`define OPTIMIZER_DEFS_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ADDR_STATUS        8'h00
`define ADDR_CAP_LEVEL     8'h05
`define ADDR_PROFILE_LOW   8'h07
`define ADDR_PROFILE_CTRL  8'h08
`define ADDR_VOUT_SET      8'h09
`define ADDR_CHARGE_CFG    8'h10
`define ADDR_CEILING_CFG   8'h12
`define ADDR_MARGIN_CFG    8'h13
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define BIT_ON_DEMAND      0
`define BIT_FORCE_ACTIVE   1
`define BIT_START_AUTO     2
`define BIT_RELEARN        3
`define BIT_HIZ_SEL        4
`define BIT_CEILING_SEL    4
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_PROFILE        6'h01
`define RST_VOUT_CODE      4'h6
`define RST_CHARGE_CFG     8'h00
`define RST_CEILING_CFG    8'h10
`define RST_MARGIN         2'h3
// ---------------------------------------------------------------
// levels and encodings
// ---------------------------------------------------------------
`define CEILING_HIGH       4'hF
`define CEILING_LOW        4'hB
`define ST_STANDBY         2'h0
`define ST_CHARGE          2'h1
`define ST_ACTIVE          2'h2
`define REG_OUT_BATTERY    2'h0
`define REG_OUT_HIZ        2'h1
`define REG_OUT_REGULATE   2'h2
`define PERM_FROM_BATTERY  1'h0
`define PERM_FROM_REGNODE  1'h1
`endif

// ===== rtl/output_path_and_charge_optimizer.v
// Notes on behaviour
// - permanent output: battery in standby/charge, regulated node in active
// - high-impedance select bit resets to zero
// - hiz clear: regulated output tied to battery outside active
// - active: regulated output uses four-bit voltage code
// - hiz set: regulated output floats in standby/charge, driven in active
// - voltage code resets to the 3.0 V code
// - voltage code rewrites in active take effect without leaving active
// - up to 63 learned profiles, nonzero profile numbers
// - each profile's target kept in hidden storage
// - profile zero disables optimizer, fixed target used
// - reset selects profile 1 and margin code 11b
// - host changes profile and margin by register writes
// - learning start loads target with the selected ceiling
// - register write or start pin begins on-demand charge
// - charge complete moves automatically to active
// - residual above margin lowers learned target one step
// - residual below margin raises learned target one or more steps
// - learning restarts at power-on or on relearn bit write
// - margin codes map to lowest four target steps
// - charge target never above selected ceiling
// - clearing on-demand bit ends active, back to standby
`timescale 1ns/100ps
`include "optimizer_defs.vh"

module output_path_and_charge_optimizer (
   input  wire       clk_sys,
   input  wire       sys_rst,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_we,
   input  wire       reg_re,
   output reg  [7:0] reg_rdata,
   input  wire       start_pin,
   input  wire [3:0] cap_level,
   output reg        permanent_supply_sel,
   output reg  [1:0] regulated_mode,
   output reg  [3:0] vset_out,
   output reg        charge_en,
   output reg  [3:0] charge_target,
   output reg  [1:0] state_out
);
   // ------------------------------------------------------------
   // state and registers
   // ------------------------------------------------------------
   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg  [5:0]  profile_reg;
   reg         on_demand_reg;
   reg         on_demand_next;
   reg         force_act_reg;
   reg         start_auto_reg;
   reg  [3:0]  vout_code_reg;
   reg  [7:0]  charge_cfg_reg;
   reg  [7:0]  ceiling_cfg_reg;
   reg  [1:0]  margin_reg;
   reg  [63:0] learned_reg;
   reg  [63:0] learned_next;
   reg  [1:0]  start_sync_reg;
   reg         start_prev_reg;
   reg  [3:0]  cap_meta_reg;
   reg  [3:0]  cap_reg;
   wire [3:0]  stored_target;
   wire [3:0]  ceiling;
   wire [3:0]  learned_target;
   reg  [3:0]  raw_target;
   wire [3:0]  eff_target;
   wire [3:0]  margin_thr;
   wire        start_edge;
   wire        wr_ctrl;
   wire        optimizing;
   wire        init_now;
   wire        end_active;
   wire [5:0]  rd_profile;
   reg         mem_we;
   reg  [3:0]  mem_wdata;
   reg  [4:0]  raised;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   // pin and analog level come from outside the clock domain;
   // cap level changes slowly, so a code skew lasts one cycle
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         start_sync_reg <= 2'h0;
         start_prev_reg <= 1'h0;
         cap_meta_reg   <= 4'h0;
         cap_reg        <= 4'h0;
      end else begin
         start_sync_reg <= {start_sync_reg[0], start_pin};
         start_prev_reg <= start_sync_reg[1];
         cap_meta_reg   <= cap_level;
         cap_reg        <= cap_meta_reg;
      end
   end

   assign start_edge = start_sync_reg[1] & ~start_prev_reg;

   // ------------------------------------------------------------
   // target selection
   // ------------------------------------------------------------
   assign ceiling = ceiling_cfg_reg[`BIT_CEILING_SEL] ?
                    `CEILING_HIGH : `CEILING_LOW;
   assign optimizing = (profile_reg != 6'h00);
   // a profile not yet learned starts at the ceiling
   assign learned_target = learned_reg[profile_reg] ?
                           stored_target : ceiling;

   // fixed target when the optimizer is off
   always @* begin
      if (optimizing) begin
         raw_target = learned_target;
      end else begin
         raw_target = ceiling_cfg_reg[3:0];
      end
   end

   // clamp protects the capacitor whatever is programmed
   assign eff_target = (raw_target > ceiling) ?
                       ceiling : raw_target;
   assign margin_thr = {2'h0, margin_reg};

   // ------------------------------------------------------------
   // state machine
   // ------------------------------------------------------------
   assign wr_ctrl = reg_we & (reg_addr == `ADDR_PROFILE_CTRL);
   assign end_active = (state_reg == `ST_ACTIVE) & ~on_demand_reg;
   assign init_now = (state_reg == `ST_CHARGE) & optimizing &
                     ~learned_reg[profile_reg];

   // next on-demand bit: pin start wins over a clearing write
   always @* begin
      on_demand_next = on_demand_reg;
      if (wr_ctrl) begin
         on_demand_next = reg_wdata[`BIT_ON_DEMAND];
      end
      if (start_edge & start_auto_reg) begin
         on_demand_next = 1'h1;
      end
   end

   always @* begin
      case (state_reg)
         `ST_STANDBY: begin
            if (on_demand_reg) begin
               state_next = `ST_CHARGE;
            end else begin
               state_next = `ST_STANDBY;
            end
         end
         `ST_CHARGE: begin
            if (~on_demand_reg) begin
               state_next = `ST_STANDBY;
            end else if (force_act_reg) begin
               state_next = `ST_ACTIVE;
            end else if (~init_now & (cap_reg >= eff_target)) begin
               state_next = `ST_ACTIVE;
            end else begin
               state_next = `ST_CHARGE;
            end
         end
         `ST_ACTIVE: begin
            // a new voltage code does not disturb this state
            if (~on_demand_reg) begin
               state_next = `ST_STANDBY;
            end else begin
               state_next = `ST_ACTIVE;
            end
         end
         default: begin
            state_next = `ST_STANDBY;
         end
      endcase
   end

   // ------------------------------------------------------------
   // optimizer update
   // ------------------------------------------------------------
   // an empty capacitor means the load was badly starved,
   // so the target climbs two steps instead of one
   always @* begin
      mem_we    = 1'h0;
      mem_wdata = learned_target;
      raised    = {1'h0, learned_target};
      if (init_now) begin
         mem_we    = 1'h1;
         mem_wdata = ceiling;
      end else if (end_active & optimizing) begin
         if (cap_reg > margin_thr) begin
            mem_we = 1'h1;
            if (learned_target != 4'h0) begin
               mem_wdata = learned_target - 4'h1;
            end
         end else if (cap_reg < margin_thr) begin
            mem_we = 1'h1;
            if (cap_reg == 4'h0) begin
               raised = {1'h0, learned_target} + 5'h02;
            end else begin
               raised = {1'h0, learned_target} + 5'h01;
            end
            if (raised > {1'h0, ceiling}) begin
               mem_wdata = ceiling;
            end else begin
               mem_wdata = raised[3:0];
            end
         end
      end
   end

   // learned flags: hardware set wins over a relearn clear
   always @* begin
      learned_next = learned_reg;
      if (wr_ctrl & reg_wdata[`BIT_RELEARN]) begin
         learned_next[profile_reg] = 1'h0;
      end
      if (mem_we) begin
         learned_next[profile_reg] = 1'h1;
      end
   end

   // read ahead on a profile write, so the stored word never lags
   assign rd_profile = (reg_we & (reg_addr == `ADDR_PROFILE_LOW)) ?
                       reg_wdata[5:0] : profile_reg;

   // hidden per-profile storage, written only at profile_reg
   target_store u_store (
      .clk_sys (clk_sys),
      .wr_en   (mem_we),
      .wr_addr (profile_reg),
      .wr_data (mem_wdata),
      .rd_addr (rd_profile),
      .rd_data (stored_target)
   );

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   // reset forgets every profile, so learning restarts
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg       <= `ST_STANDBY;
         profile_reg     <= `RST_PROFILE;
         on_demand_reg   <= 1'h0;
         force_act_reg   <= 1'h0;
         start_auto_reg  <= 1'h0;
         vout_code_reg   <= `RST_VOUT_CODE;
         charge_cfg_reg  <= `RST_CHARGE_CFG;
         ceiling_cfg_reg <= `RST_CEILING_CFG;
         margin_reg      <= `RST_MARGIN;
         learned_reg     <= 64'h0;
      end else begin
         state_reg     <= state_next;
         on_demand_reg <= on_demand_next;
         learned_reg   <= learned_next;
         if (wr_ctrl) begin
            force_act_reg  <= reg_wdata[`BIT_FORCE_ACTIVE];
            start_auto_reg <= reg_wdata[`BIT_START_AUTO];
         end
         if (reg_we) begin
            case (reg_addr)
               `ADDR_PROFILE_LOW: begin
                  profile_reg <= reg_wdata[5:0];
               end
               `ADDR_VOUT_SET: begin
                  vout_code_reg <= reg_wdata[3:0];
               end
               `ADDR_CHARGE_CFG: begin
                  charge_cfg_reg <= reg_wdata;
               end
               `ADDR_CEILING_CFG: begin
                  ceiling_cfg_reg <= reg_wdata;
               end
               `ADDR_MARGIN_CFG: begin
                  margin_reg <= reg_wdata[1:0];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // read port, one cycle latency; unmapped reads give zero
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_re) begin
         case (reg_addr)
            `ADDR_STATUS:       reg_rdata <= {6'h00, state_reg};
            `ADDR_CAP_LEVEL:    reg_rdata <= {4'h0, cap_reg};
            `ADDR_PROFILE_LOW:  reg_rdata <= {2'h0, profile_reg};
            `ADDR_PROFILE_CTRL: reg_rdata <= {5'h00, start_auto_reg,
                                              force_act_reg,
                                              on_demand_reg};
            `ADDR_VOUT_SET:     reg_rdata <= {4'h0, vout_code_reg};
            `ADDR_CHARGE_CFG:   reg_rdata <= charge_cfg_reg;
            `ADDR_CEILING_CFG:  reg_rdata <= ceiling_cfg_reg;
            `ADDR_MARGIN_CFG:   reg_rdata <= {6'h00, margin_reg};
            default:            reg_rdata <= 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // output switches
   // ------------------------------------------------------------
   // outputs lag the state by one cycle, as all are flopped
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         permanent_supply_sel <= `PERM_FROM_BATTERY;
         regulated_mode       <= `REG_OUT_BATTERY;
         vset_out             <= `RST_VOUT_CODE;
         charge_en            <= 1'h0;
         charge_target        <= 4'h0;
         state_out            <= `ST_STANDBY;
      end else begin
         state_out     <= state_reg;
         vset_out      <= vout_code_reg;
         charge_en     <= (state_reg == `ST_CHARGE);
         charge_target <= eff_target;
         if (state_reg == `ST_ACTIVE) begin
            permanent_supply_sel <= `PERM_FROM_REGNODE;
            regulated_mode       <= `REG_OUT_REGULATE;
         end else begin
            permanent_supply_sel <= `PERM_FROM_BATTERY;
            if (charge_cfg_reg[`BIT_HIZ_SEL]) begin
               regulated_mode <= `REG_OUT_HIZ;
            end else begin
               regulated_mode <= `REG_OUT_BATTERY;
            end
         end
      end
   end
endmodule // output_path_and_charge_optimizer

// ===== rtl/target_store.v
`timescale 1ns/100ps
// ---------------------------------------------------------------
// learned charge targets, one word per profile
// ---------------------------------------------------------------
module target_store (
   input  wire       clk_sys,
   input  wire       wr_en,
   input  wire [5:0] wr_addr,
   input  wire [3:0] wr_data,
   input  wire [5:0] rd_addr,
   output reg  [3:0] rd_data
);
   reg [3:0] mem [0:63];

   // registered read; no reset, validity is tracked outside;
   // a same-word write is forwarded so the new target shows at once
   always @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (wr_en && (wr_addr == rd_addr)) begin
         rd_data <= wr_data;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule // target_store

// ===== testbench/host_model.sv
`timescale 1ns/100ps
module host_model (
   input  wire       clk_sys,
   input  wire [7:0] reg_rdata,
   output reg  [7:0] reg_addr,
   output reg  [7:0] reg_wdata,
   output reg        reg_we,
   output reg        reg_re,
   output reg        start_pin
);
   // idle bus at time zero
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_we    = 1'b0;
      reg_re    = 1'b0;
      start_pin = 1'b0;
   end
   // one write; released lines show inverse so stale data cannot match
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk_sys);
         reg_addr  <= a;
         reg_wdata <= d;
         reg_we    <= 1'b1;
         @(posedge clk_sys);
         reg_we    <= 1'b0;
         reg_addr  <= ~a;
         reg_wdata <= ~d;
      end
   endtask
   // one read; data registered at the edge that takes the strobe
   task rd(input [7:0] a, output [7:0] d);
      begin
         @(posedge clk_sys);
         reg_addr <= a;
         reg_re   <= 1'b1;
         @(posedge clk_sys);
         reg_re   <= 1'b0;
         reg_addr <= ~a;
         #1 d = reg_rdata;
      end
   endtask
   // pin held long enough for the two-flop synchroniser
   task pulse_start;
      begin
         @(posedge clk_sys) start_pin <= 1'b1;
         repeat (4) @(posedge clk_sys);
         start_pin <= 1'b0;
      end
   endtask
endmodule // host_model

// ===== testbench/optimizer_assertions.sv
`timescale 1ns/100ps
module optimizer_assertions (
   input wire       clk_sys,
   input wire       sys_rst,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_we,
   input wire       reg_re,
   input wire [7:0] reg_rdata,
   input wire       start_pin,
   input wire [3:0] cap_level,
   input wire       permanent_supply_sel,
   input wire [1:0] regulated_mode,
   input wire [3:0] vset_out,
   input wire       charge_en,
   input wire [3:0] charge_target,
   input wire [1:0] state_out
);
   reg       hiz_reg;
   reg       ceil_reg;
   reg [3:0] vset_reg;
   reg [1:0] age_reg;
   wire      od_wr = reg_we && reg_addr == 8'h08;
   // shadow of config writes; age lets outputs settle after a write
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         hiz_reg  <= 1'b0;
         ceil_reg <= 1'b1;
         vset_reg <= 4'h6;
         age_reg  <= 2'h0;
      end else begin
         if (reg_we) age_reg <= 2'h0;
         else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
         if (reg_we && reg_addr == 8'h10) hiz_reg <= reg_wdata[4];
         if (reg_we && reg_addr == 8'h12) ceil_reg <= reg_wdata[4];
         if (reg_we && reg_addr == 8'h09) vset_reg <= reg_wdata[3:0];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_perm; permanent_supply_sel == (state_out == 2'h2);
   endproperty
   a_perm: assert property (p_perm) else $error("perm path");
   property p_reg_act; (state_out == 2'h2) == (regulated_mode == 2'h2);
   endproperty
   a_reg_act: assert property (p_reg_act) else $error("reg act");
   property p_reg_idle; state_out != 2'h2 && age_reg == 2'h3
      |-> regulated_mode == {1'b0, hiz_reg}; endproperty
   a_reg_idle: assert property (p_reg_idle) else $error("idle");
   property p_vset; age_reg == 2'h3 |-> vset_out == vset_reg;
   endproperty
   a_vset: assert property (p_vset) else $error("vset");
   property p_ceil; charge_en && age_reg == 2'h3
      |-> charge_target <= (ceil_reg ? 4'hF : 4'hB); endproperty
   a_ceil: assert property (p_ceil) else $error("ceiling");
   property p_to_act; (state_out == 2'h1 && cap_level >= charge_target)[*4]
      |-> ##[0:3] state_out == 2'h2; endproperty
   a_to_act: assert property (p_to_act) else $error("no active");
   property p_od; od_wr && reg_wdata[0] && state_out == 2'h0
      |-> ##[2:4] state_out == 2'h1; endproperty
   a_od: assert property (p_od) else $error("no charge");
   property p_end; od_wr && !reg_wdata[0] && state_out == 2'h2
      |-> ##[1:3] state_out == 2'h0; endproperty
   a_end: assert property (p_end) else $error("no standby");
   property p_rst; $fell(sys_rst) |-> regulated_mode == 2'h0
      && vset_out == 4'h6; endproperty
   a_rst: assert property (p_rst) else $error("reset out");
endmodule // optimizer_assertions

bind output_path_and_charge_optimizer optimizer_assertions u_chk (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
   .reg_rdata(reg_rdata), .start_pin(start_pin), .cap_level(cap_level),
   .permanent_supply_sel(permanent_supply_sel),
   .regulated_mode(regulated_mode), .vset_out(vset_out),
   .charge_en(charge_en), .charge_target(charge_target),
   .state_out(state_out));

// ===== testbench/tb.sv
`timescale 1ns/100ps
module tb;
   reg        clk_sys;
   reg        sys_rst;
   reg  [3:0] cap_level;
   wire [7:0] reg_addr, reg_wdata, reg_rdata;
   wire       reg_we, reg_re, start_pin, permanent_supply_sel, charge_en;
   wire [1:0] regulated_mode, state_out;
   wire [3:0] vset_out, charge_target;
   integer    n_mismatch, compares, i, prof, marg, ceil, fixv, hiz;
   integer    tgt [0:63];
   reg  [7:0] rv;
   localparam [55:0] rst_addr = 56'h07_08_09_10_12_13_3C;
   localparam [55:0] rst_val  = 56'h01_00_06_00_10_03_00;

   output_path_and_charge_optimizer u_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
      .reg_rdata(reg_rdata), .start_pin(start_pin), .cap_level(cap_level),
      .permanent_supply_sel(permanent_supply_sel),
      .regulated_mode(regulated_mode), .vset_out(vset_out),
      .charge_en(charge_en), .charge_target(charge_target),
      .state_out(state_out));
   host_model u_host (
      .clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
      .start_pin(start_pin));

   // 50 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task chk(input [7:0] seen, input integer exp);
      begin
         compares = compares + 1;
         if (seen !== exp[7:0]) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
         end
      end
   endtask
   task tally_and_finish;
      begin
         if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // bounded wait; a hang counts as a mismatch and ends the run
   task wait_st(input [1:0] s);
      integer n;
      begin
         n = 0;
         while (state_out !== s && n < 60) begin
            @(posedge clk_sys);
            #1 n = n + 1;
         end
         if (state_out !== s) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish;
         end
      end
   endtask
   // one on-demand cycle against the learned-target model
   task cycle(input integer pin, input integer resid);
      integer t;
      begin
         @(posedge clk_sys) cap_level <= 4'h0;
         if (pin) begin
            u_host.wr(8'h08, 8'h04);
            u_host.pulse_start;
         end else u_host.wr(8'h08, 8'h01);
         wait_st(2'h1);
         if (prof != 0 && tgt[prof] < 0) tgt[prof] = ceil;
         t = prof ? tgt[prof] : (fixv < ceil ? fixv : ceil);
         repeat (3) @(posedge clk_sys);
         #1 chk(charge_target, t);
         chk({6'h00, regulated_mode}, hiz);
         chk({7'h00, charge_en}, 1);
         chk({7'h00, permanent_supply_sel}, 0);
         @(posedge clk_sys) cap_level <= 4'($urandom_range(15, t));
         wait_st(2'h2);
         @(posedge clk_sys) cap_level <= 4'(resid);
         #1 chk({6'h00, regulated_mode}, 2);
         chk({7'h00, permanent_supply_sel}, 1);
         rv = 8'($urandom);
         u_host.wr(8'h09, rv);
         repeat (3) @(posedge clk_sys);
         #1 chk(vset_out, rv[3:0]);
         chk({6'h00, state_out}, 2);
         u_host.wr(8'h08, 8'h00);
         wait_st(2'h0);
         if (prof != 0) begin
            // equal residual leaves the target alone
            if (resid > marg && tgt[prof] > 0) tgt[prof] -= 1;
            else if (resid < marg) tgt[prof] += resid == 0 ? 2 : 1;
            if (tgt[prof] > ceil) tgt[prof] = ceil;
         end
      end
   endtask
   // main sequence
   initial begin
      n_mismatch = 0;
      compares = 0;
      sys_rst = 1'b1;
      cap_level = 4'h0;
      prof = 1;
      marg = 3;
      ceil = 15;
      fixv = 0;
      hiz = 0;
      for (i = 0; i < 64; i++) tgt[i] = -1;
      rv = 8'($urandom(50571));
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (i = 0; i < 7; i++) begin
         u_host.rd(rst_addr[8*(6-i) +: 8], rv);
         chk(rv, rst_val[8*(6-i) +: 8]);
      end
      repeat (5) cycle(0, $urandom_range(5, 0));
      u_host.wr(8'h10, 8'h10);
      hiz = 1;
      cycle(1, 3);
      u_host.wr(8'h07, 8'h3F);
      prof = 63;
      cycle(0, 1);
      cycle(0, 6);
      u_host.wr(8'h07, 8'h01);
      prof = 1;
      cycle(0, 2);
      for (i = 0; i < 4; i++) begin
         u_host.wr(8'h13, i[7:0]);
         marg = i;
         cycle(0, $urandom_range(4, 0));
      end
      u_host.wr(8'h08, 8'h08);
      tgt[1] = -1;
      cycle(0, 0);
      u_host.wr(8'h07, 8'h00);
      prof = 0;
      u_host.wr(8'h12, 8'h0E);
      ceil = 11;
      fixv = 14;
      cycle(0, 0);
      u_host.wr(8'h12, 8'h15);
      ceil = 15;
      fixv = 5;
      cycle(0, 2);
      // force active skips the charge wait; status read follows state, cap level read gives the residual
      u_host.wr(8'h08, 8'h03);
      wait_st(2'h2);
      u_host.rd(8'h00, rv);
      chk(rv, 2);
      u_host.rd(8'h05, rv);
      chk(rv, 2);
      u_host.wr(8'h08, 8'h00);
      wait_st(2'h0);
      // pin is refused while the start-pin enable is clear
      u_host.pulse_start;
      repeat (4) @(posedge clk_sys);
      #1 chk({6'h00, state_out}, 0);
      chk({7'h00, charge_en}, 0);
      tally_and_finish;
   end
endmodule // tb
